// file: tmr_top.sv
// Top of the 16-bit timer slice with capture, forced compare and AXI4-Lite registers
// Assumes pins synchronous to aclk; one read and one write in flight at most
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module tmr_top #(
  parameter int CNT_W = 16
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // AXI4-Lite write
  input wire logic [tmr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [tmr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic capture_pin,
  input wire logic comparator_out,
  input wire logic ext_clock_pin,
  // Outputs
  output logic wave_out_a,
  output logic wave_out_b,
  output logic irq
);
  typedef struct packed {
    logic [7:0] clk_ctrl;
    logic [7:0] wave_ctrl;
    logic [CNT_W-1:0] counter_value;
    logic [CNT_W-1:0] capture_value;
    logic [CNT_W-1:0] compare_a_value;
    logic [7:0] temp_hi;
    logic [tmr_pkg::PRESC_W-1:0] presc;
    logic ext_prev;
    logic block_match;
    logic [2:0] status;
    logic [2:0] mask;
    logic out_a;
    logic out_b;
    logic irq;
    logic aw_got;
    logic [tmr_pkg::ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tmr_state_s;

  tmr_state_s st_reg;
  tmr_state_s st_next;
  tmr_cap_if cap ();

  tmr_capture_cond u_cond (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .capture_pin(capture_pin),
    .comparator_out(comparator_out),
    .cap(cap)
  );

  logic [3:0] wmode;
  logic cap_is_top;
  logic pwm_mode;
  logic tick;
  logic [CNT_W-1:0] top_val;
  logic match_a;
  logic wr_fire;
  logic [7:0] widx;
  logic [7:0] ridx;
  logic [7:0] rbyte;
  logic rok;
  logic wok;

  assign wmode = {st_reg.clk_ctrl[tmr_pkg::WAVE3_BIT], st_reg.clk_ctrl[tmr_pkg::WAVE2_BIT], st_reg.wave_ctrl[1:0]};
  assign cap_is_top = (wmode == tmr_pkg::WM_PFC_CAP) || (wmode == tmr_pkg::WM_PC_CAP) ||
                      (wmode == tmr_pkg::WM_CTC_CAP) || (wmode == tmr_pkg::WM_FAST_CAP);
  assign pwm_mode = !((wmode == tmr_pkg::WM_NORMAL) || (wmode == tmr_pkg::WM_CTC_A) || (wmode == tmr_pkg::WM_CTC_CAP));
  assign cap.filter_en = st_reg.clk_ctrl[tmr_pkg::FLT_EN_BIT];
  assign cap.edge_sel = st_reg.clk_ctrl[tmr_pkg::EDGE_SEL_BIT];
  assign cap.src_sel = st_reg.wave_ctrl[tmr_pkg::CMP_SRC_BIT];
  assign cap.capture_en = !cap_is_top;

  always_comb begin
    tick = 1'b0;
    case (st_reg.clk_ctrl[2:0])
      tmr_pkg::CS_STOP: tick = 1'b0;
      tmr_pkg::CS_DIV1: tick = 1'b1;
      tmr_pkg::CS_DIV8: tick = &st_reg.presc[2:0];
      tmr_pkg::CS_DIV64: tick = &st_reg.presc[5:0];
      tmr_pkg::CS_DIV256: tick = &st_reg.presc[7:0];
      tmr_pkg::CS_DIV1024: tick = &st_reg.presc[9:0];
      tmr_pkg::CS_EXT_FALL: tick = st_reg.ext_prev & ~ext_clock_pin;
      tmr_pkg::CS_EXT_RISE: tick = ~st_reg.ext_prev & ext_clock_pin;
      default: tick = 1'b0;
    endcase
    top_val = tmr_pkg::MAX_16[CNT_W-1:0];
    if (wmode == tmr_pkg::WM_CTC_A) begin
      top_val = st_reg.compare_a_value;
    end else if (wmode == tmr_pkg::WM_CTC_CAP) begin
      top_val = st_reg.capture_value;
    end
  end

  assign match_a = tick && !st_reg.block_match && (st_reg.counter_value == st_reg.compare_a_value);

  // Compare output action for a match: [1:0] mode 01 toggle, 10 clear, 11 set
  function automatic logic wave_act(input logic [1:0] com, input logic cur);
    case (com)
      2'h1: wave_act = ~cur;
      2'h2: wave_act = 1'b0;
      2'h3: wave_act = 1'b1;
      default: wave_act = cur;
    endcase
  endfunction : wave_act

  always_comb begin
    st_next = st_reg;
    wr_fire = 1'b0;
    widx = st_reg.aw_addr[tmr_pkg::ADDR_W-1:tmr_pkg::ADDR_LSB];
    ridx = s_axi_araddr[tmr_pkg::ADDR_W-1:tmr_pkg::ADDR_LSB];
    rbyte = tmr_pkg::RESET_8;
    rok = 1'b1;
    wok = 1'b1;
    st_next.presc = st_reg.presc + 1'b1;
    st_next.ext_prev = ext_clock_pin;
    if (tick) begin
      st_next.block_match = 1'b0;
      if (st_reg.counter_value == top_val) begin
        st_next.counter_value = '0;
        if (top_val == tmr_pkg::MAX_16[CNT_W-1:0]) begin
          st_next.status[tmr_pkg::IRQ_OVF_BIT] = 1'b1;
        end
      end else begin
        st_next.counter_value = st_reg.counter_value + 1'b1;
      end
    end
    if (match_a) begin
      st_next.status[tmr_pkg::IRQ_MATCH_A_BIT] = 1'b1;
      st_next.out_a = wave_act(st_reg.wave_ctrl[3:2], st_reg.out_a);
    end
    // AXI write channel capture
    if (s_axi_awvalid && !st_reg.aw_got) begin
      st_next.aw_got = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_got) begin
      st_next.w_got = 1'b1;
      st_next.w_data = s_axi_wdata[7:0];
      st_next.w_strb0 = s_axi_wstrb[0];
    end
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
      wr_fire = st_reg.w_strb0;
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      case (widx)
        tmr_pkg::IDX_CLK_CTRL, tmr_pkg::IDX_FORCE_CTRL, tmr_pkg::IDX_CNT_LO, tmr_pkg::IDX_CNT_HI,
        tmr_pkg::IDX_CAP_LO, tmr_pkg::IDX_CAP_HI, tmr_pkg::IDX_CMPA_LO, tmr_pkg::IDX_CMPA_HI,
        tmr_pkg::IDX_WAVE_CTRL, tmr_pkg::IDX_IRQ_STATUS, tmr_pkg::IDX_IRQ_MASK: wok = 1'b1;
        default: wok = 1'b0;
      endcase
      st_next.bresp = wok ? tmr_pkg::AXI_OKAY : tmr_pkg::AXI_SLVERR;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (wr_fire) begin
      case (widx)
        tmr_pkg::IDX_CLK_CTRL: st_next.clk_ctrl = st_reg.w_data & tmr_pkg::CLK_CTRL_WMASK;
        tmr_pkg::IDX_WAVE_CTRL: st_next.wave_ctrl = st_reg.w_data & tmr_pkg::WAVE_CTRL_WMASK;
        tmr_pkg::IDX_IRQ_MASK: st_next.mask = st_reg.w_data[2:0] & tmr_pkg::IRQ_BITS_MASK;
        tmr_pkg::IDX_FORCE_CTRL: begin
          // Forced match moves only the outputs: no flag, no clear
          if (!pwm_mode) begin
            if (st_reg.w_data[tmr_pkg::FORCE_A_BIT]) begin
              st_next.out_a = wave_act(st_reg.wave_ctrl[3:2], st_reg.out_a);
            end
            if (st_reg.w_data[tmr_pkg::FORCE_B_BIT]) begin
              st_next.out_b = wave_act(st_reg.wave_ctrl[5:4], st_reg.out_b);
            end
          end
        end
        tmr_pkg::IDX_CNT_HI, tmr_pkg::IDX_CAP_HI, tmr_pkg::IDX_CMPA_HI: st_next.temp_hi = st_reg.w_data;
        tmr_pkg::IDX_CNT_LO: begin
          st_next.counter_value = {st_reg.temp_hi, st_reg.w_data};
          st_next.block_match = 1'b1;
        end
        tmr_pkg::IDX_CAP_LO: st_next.capture_value = {st_reg.temp_hi, st_reg.w_data};
        tmr_pkg::IDX_CMPA_LO: st_next.compare_a_value = {st_reg.temp_hi, st_reg.w_data};
        default: st_next.temp_hi = st_reg.temp_hi;
      endcase
    end
    // Capture after register writes so the hardware event wins
    if (cap.event_pulse) begin
      st_next.capture_value = st_reg.counter_value;
    end
    // AXI read
    if (s_axi_arvalid && !st_reg.rvalid) begin
      case (ridx)
        tmr_pkg::IDX_CLK_CTRL: rbyte = st_reg.clk_ctrl;
        tmr_pkg::IDX_FORCE_CTRL: rbyte = tmr_pkg::RESET_8;
        tmr_pkg::IDX_CNT_LO: begin
          rbyte = st_reg.counter_value[7:0];
          st_next.temp_hi = st_reg.counter_value[15:8];
        end
        tmr_pkg::IDX_CAP_LO: begin
          rbyte = st_reg.capture_value[7:0];
          st_next.temp_hi = st_reg.capture_value[15:8];
        end
        tmr_pkg::IDX_CMPA_LO: rbyte = st_reg.compare_a_value[7:0];
        tmr_pkg::IDX_CMPA_HI: rbyte = st_reg.compare_a_value[15:8];
        tmr_pkg::IDX_CNT_HI, tmr_pkg::IDX_CAP_HI: rbyte = st_reg.temp_hi;
        tmr_pkg::IDX_WAVE_CTRL: rbyte = st_reg.wave_ctrl;
        tmr_pkg::IDX_IRQ_STATUS: begin
          rbyte = {5'h00, st_reg.status};
          st_next.status = '0;
        end
        tmr_pkg::IDX_IRQ_MASK: rbyte = {5'h00, st_reg.mask};
        default: rok = 1'b0;
      endcase
      st_next.rvalid = 1'b1;
      st_next.rdata = {24'h000000, rbyte};
      st_next.rresp = rok ? tmr_pkg::AXI_OKAY : tmr_pkg::AXI_SLVERR;
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    // Events set over the read clear
    if (match_a) begin
      st_next.status[tmr_pkg::IRQ_MATCH_A_BIT] = 1'b1;
    end
    if (tick && (st_reg.counter_value == top_val) && (top_val == tmr_pkg::MAX_16[CNT_W-1:0])) begin
      st_next.status[tmr_pkg::IRQ_OVF_BIT] = 1'b1;
    end
    if (cap.event_pulse) begin
      st_next.status[tmr_pkg::IRQ_CAP_BIT] = 1'b1;
    end
    st_next.irq = |(st_next.status & st_next.mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = !st_reg.aw_got;
  assign s_axi_wready = !st_reg.w_got;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign wave_out_a = st_reg.out_a;
  assign wave_out_b = st_reg.out_b;
  assign irq = st_reg.irq;
endmodule : tmr_top

// file: tmr_pkg.sv
// Package for the 16-bit capture timer slice: register map, fields, reset values, timing
// Assumes AXI4-Lite register access with 32-bit data, one aligned word per register
package tmr_pkg;
  // Printed offsets are not all multiples of four: they are register indices
  localparam logic [7:0] IDX_CLK_CTRL = 8'h91;
  localparam logic [7:0] IDX_FORCE_CTRL = 8'h92;
  localparam logic [7:0] IDX_CNT_LO = 8'h94;
  localparam logic [7:0] IDX_CNT_HI = 8'h95;
  localparam logic [7:0] IDX_CAP_LO = 8'h96;
  localparam logic [7:0] IDX_CAP_HI = 8'h97;
  localparam logic [7:0] IDX_CMPA_LO = 8'h98;
  localparam logic [7:0] IDX_CMPA_HI = 8'h99;
  localparam logic [7:0] IDX_WAVE_CTRL = 8'ha0;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'ha1;
  localparam logic [7:0] IDX_IRQ_MASK = 8'ha2;
  localparam int ADDR_W = 10;
  localparam int ADDR_LSB = 2;
  // capture_clock_ctrl fields
  localparam int FLT_EN_BIT = 7;
  localparam int EDGE_SEL_BIT = 6;
  localparam int WAVE3_BIT = 4;
  localparam int WAVE2_BIT = 3;
  localparam logic [7:0] CLK_CTRL_WMASK = 8'hdf;
  // force_compare_ctrl fields
  localparam int FORCE_A_BIT = 7;
  localparam int FORCE_B_BIT = 6;
  // wave_ctrl: [1:0] low mode bits, [3:2] mode A, [5:4] mode B, [6] comparator capture source
  localparam int CMP_SRC_BIT = 6;
  localparam logic [7:0] WAVE_CTRL_WMASK = 8'h7f;
  // irq status/mask bits
  localparam int IRQ_CAP_BIT = 0;
  localparam int IRQ_MATCH_A_BIT = 1;
  localparam int IRQ_OVF_BIT = 2;
  localparam logic [2:0] IRQ_BITS_MASK = 3'h7;
  localparam logic [7:0] RESET_8 = 8'h00;
  localparam logic [15:0] RESET_16 = 16'h0000;
  localparam logic [15:0] MAX_16 = 16'hffff;
  // Clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int PRESC_W = 10;
  localparam int FILTER_SAMPLES = 4;
  // Waveform modes that matter here
  localparam logic [3:0] WM_NORMAL = 4'h0;
  localparam logic [3:0] WM_CTC_A = 4'h4;
  localparam logic [3:0] WM_PFC_CAP = 4'h8;
  localparam logic [3:0] WM_PC_CAP = 4'ha;
  localparam logic [3:0] WM_CTC_CAP = 4'hc;
  localparam logic [3:0] WM_FAST_CAP = 4'he;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : tmr_pkg

// file: tmr_cap_if.sv
// Interface between the timer core and the capture input conditioner
// Assumes both ends share aclk
`timescale 1ns/10ps
interface tmr_cap_if;
  logic filter_en;
  logic edge_sel;
  logic src_sel;
  logic capture_en;
  logic event_pulse;
  modport core (output filter_en, output edge_sel, output src_sel, output capture_en, input event_pulse);
  modport cond (input filter_en, input edge_sel, input src_sel, input capture_en, output event_pulse);
endinterface : tmr_cap_if

// file: tmr_capture_cond.sv
// Capture input conditioner: optional four-sample filter and edge detection
// Assumes capture_pin and comparator input synchronous to aclk
`timescale 1ns/10ps
module tmr_capture_cond (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // Raw inputs
  input wire logic capture_pin,
  input wire logic comparator_out,
  // Core side
  tmr_cap_if.cond cap
);
  typedef struct packed {
    logic [tmr_pkg::FILTER_SAMPLES-1:0] hist;
    logic filt;
    logic prev;
    logic evt;
  } tmr_cond_s;
  tmr_cond_s st_reg;
  tmr_cond_s st_next;
  logic raw;
  logic cur;

  always_comb begin
    st_next = st_reg;
    raw = cap.src_sel ? comparator_out : capture_pin;
    st_next.hist = {st_reg.hist[tmr_pkg::FILTER_SAMPLES-2:0], raw};
    // Output changes only once the last four samples all agree
    if (&st_next.hist) begin
      st_next.filt = 1'b1;
    end else if (~|st_next.hist) begin
      st_next.filt = 1'b0;
    end
    cur = cap.filter_en ? st_next.filt : raw;
    st_next.prev = cur;
    st_next.evt = cap.capture_en & (cap.edge_sel ? (cur & ~st_reg.prev) : (~cur & st_reg.prev));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign cap.event_pulse = st_reg.evt & clk_en;
endmodule : tmr_capture_cond

// file: tmr_pin_model.sv
// Far-side model of the timer pins: capture input, comparator output, external clock
// Assumes the bench calls its tasks; every change lands just after a rising aclk edge
`timescale 1ns/10ps
module tmr_pin_model (
  // Clock
  input wire logic aclk,
  // Pins toward the timer
  output logic capture_pin,
  output logic comparator_out,
  output logic ext_clock_pin
);
  logic [2:0] pins = 3'h0;
  assign capture_pin = pins[0];
  assign comparator_out = pins[1];
  assign ext_clock_pin = pins[2];
  // Set one pin, then let it settle
  task automatic level(input int sel, input logic v);
    @(posedge aclk);
    pins[sel] <= v;
    repeat (12) @(posedge aclk);
  endtask : level
  // High for hi cycles then low, n times
  task automatic pulse(input int sel, input int hi, input int n);
    repeat (n) begin
      @(posedge aclk);
      pins[sel] <= 1'b1;
      repeat (hi) @(posedge aclk);
      pins[sel] <= 1'b0;
      repeat (12) @(posedge aclk);
    end
  endtask : pulse
endmodule : tmr_pin_model

// file: tmr_top_chk.sv
// Checker for the timer slice: bus answers, zero read-back fields, reset state
// Sees only the top ports; bound to every tmr_top instance
`timescale 1ns/10ps
module tmr_top_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [tmr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // Outputs
  input wire logic irq,
  input wire logic wave_out_a,
  input wire logic wave_out_b
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar(logic [7:0] idx);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == {idx, 2'b00};
  endsequence
  sequence s_aw;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence s_wr_both;
    s_aw ##0 (s_axi_wvalid && s_axi_wready && !s_axi_bvalid);
  endsequence
  chk_force_reads_zero: assert property (s_ar(tmr_pkg::IDX_FORCE_CTRL) |=> s_axi_rdata[7:0] == 8'h00)
    else $error("force register read back nonzero");
  chk_ctrl_gap_zero: assert property (s_ar(tmr_pkg::IDX_CLK_CTRL) |=> !s_axi_rdata[5])
    else $error("unused control bit read as one");
  chk_unmapped_err: assert property (s_ar(8'h93) |=> s_axi_rresp == tmr_pkg::AXI_SLVERR)
    else $error("unmapped read not refused");
  chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data above the byte lane nonzero");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_write_answer: assert property (s_wr_both |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  chk_aw_busy: assert property (s_aw |=> !s_axi_awready)
    else $error("address ready while write pending");
  chk_reset_state: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_rvalid && !s_axi_bvalid && !irq && !wave_out_a && !wave_out_b)
    else $error("outputs not cleared by reset");
endmodule : tmr_top_chk
bind tmr_top tmr_top_chk i_chk (.*);

// file: tmr_top_test.sv
// Self-checking bench for the timer slice over AXI4-Lite
// Assumes the bound checker and the pin model on the far side
`timescale 1ns/10ps
module tmr_top_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [9:0] s_axi_awaddr = 10'h000;
  logic [9:0] s_axi_araddr = 10'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic irq, wave_out_a, wave_out_b, capture_pin, comparator_out, ext_clock_pin;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] rd_d;
  logic [15:0] v16;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int div [5] = '{32'h1, 32'h8, 32'h40, 32'h100, 32'h400};
  tmr_top i_dut (.clk_en(1'b1), .s_axi_wstrb(4'h1), .*);
  tmr_pin_model i_pins (.*);
  task automatic stop_test();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk({14'h0, s_axi_bresp}, {14'h0, tmr_pkg::AXI_OKAY});
    repeat (2) @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    rd_d = s_axi_rdata[7:0];
    chk({14'h0, s_axi_rresp}, {14'h0, er});
  endtask : rd
  task automatic rc(input logic [7:0] idx, input logic [7:0] e);
    rd(idx, tmr_pkg::AXI_OKAY);
    chk({8'h0, rd_d}, {8'h0, e});
  endtask : rc
  // High byte first through the shared latch
  task automatic wr16(input logic [7:0] idx, input logic [15:0] v);
    wr(idx + 8'h01, v[15:8]);
    wr(idx, v[7:0]);
  endtask : wr16
  // Low byte first latches the high byte for counter and capture; compare A high byte is read directly
  task automatic rd16(input logic [7:0] idx, input logic [15:0] e);
    rd(idx, tmr_pkg::AXI_OKAY);
    v16[7:0] = rd_d;
    rd(idx + 8'h01, tmr_pkg::AXI_OKAY);
    v16[15:8] = rd_d;
    chk(v16, e);
  endtask : rd16
  initial begin
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 32'hafc8) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rc(tmr_pkg::IDX_CLK_CTRL, 8'h00);
    rc(tmr_pkg::IDX_FORCE_CTRL, 8'h00);
    rd16(tmr_pkg::IDX_CNT_LO, 16'h0000);
    rd16(tmr_pkg::IDX_CAP_LO, 16'h0000);
    rd16(tmr_pkg::IDX_CMPA_LO, 16'h0000);
    rd(8'h93, tmr_pkg::AXI_SLVERR);
    wr16(tmr_pkg::IDX_CMPA_LO, 16'hbeef);
    rd16(tmr_pkg::IDX_CMPA_LO, 16'hbeef);
    wr16(tmr_pkg::IDX_CNT_LO, 16'h1234);
    repeat (40) @(posedge aclk);
    rd16(tmr_pkg::IDX_CNT_LO, 16'h1234);
    wr(tmr_pkg::IDX_CLK_CTRL, 8'h07);
    i_pins.pulse(2, 3, 5);
    wr(tmr_pkg::IDX_CLK_CTRL, 8'h06);
    rd16(tmr_pkg::IDX_CNT_LO, 16'h1239);
    i_pins.pulse(2, 3, 3);
    wr(tmr_pkg::IDX_CLK_CTRL, 8'h00);
    rd16(tmr_pkg::IDX_CNT_LO, 16'h123c);
    for (int k = 0; k < 5; k++) begin
      wr16(tmr_pkg::IDX_CNT_LO, 16'h0000);
      wr(tmr_pkg::IDX_CLK_CTRL, 8'(k + 1));
      repeat (div[k] * 20) @(posedge aclk);
      wr(tmr_pkg::IDX_CLK_CTRL, 8'h00);
      rd(tmr_pkg::IDX_CNT_LO, tmr_pkg::AXI_OKAY);
      v16[7:0] = rd_d;
      rd(tmr_pkg::IDX_CNT_HI, tmr_pkg::AXI_OKAY);
      v16[15:8] = rd_d;
      chk({15'h0, v16 >= 16'h13 && v16 <= 16'(16'h15 + 16'h8 / div[k])}, 16'h0001);
    end
    wr(tmr_pkg::IDX_IRQ_MASK, 8'h01);
    wr(tmr_pkg::IDX_CLK_CTRL, 8'h40);
    wr16(tmr_pkg::IDX_CNT_LO, 16'h0a5c);
    i_pins.level(0, 1'b1);
    wr16(tmr_pkg::IDX_CNT_LO, 16'h0b00);
    i_pins.level(0, 1'b0);
    rd16(tmr_pkg::IDX_CAP_LO, 16'h0a5c);
    chk({15'h0, irq}, 16'h0001);
    rc(tmr_pkg::IDX_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge aclk);
    chk({15'h0, irq}, 16'h0000);
    wr(tmr_pkg::IDX_CLK_CTRL, 8'h00);
    i_pins.level(0, 1'b1);
    wr16(tmr_pkg::IDX_CNT_LO, 16'h0d00);
    i_pins.level(0, 1'b0);
    rd16(tmr_pkg::IDX_CAP_LO, 16'h0d00);
    wr(tmr_pkg::IDX_CLK_CTRL, 8'hc0);
    wr16(tmr_pkg::IDX_CNT_LO, 16'h0e00);
    i_pins.pulse(0, 3, 1);
    rd16(tmr_pkg::IDX_CAP_LO, 16'h0d00);
    i_pins.pulse(0, 4, 1);
    rd16(tmr_pkg::IDX_CAP_LO, 16'h0e00);
    wr(tmr_pkg::IDX_WAVE_CTRL, 8'h40);
    wr(tmr_pkg::IDX_CLK_CTRL, 8'h40);
    wr16(tmr_pkg::IDX_CNT_LO, 16'h0f00);
    i_pins.pulse(1, 4, 1);
    rd16(tmr_pkg::IDX_CAP_LO, 16'h0f00);
    wr(tmr_pkg::IDX_WAVE_CTRL, 8'h00);
    rd(tmr_pkg::IDX_IRQ_STATUS, tmr_pkg::AXI_OKAY);
    wr(tmr_pkg::IDX_CLK_CTRL, 8'h58);
    wr16(tmr_pkg::IDX_CNT_LO, 16'h1100);
    i_pins.pulse(0, 4, 1);
    rd16(tmr_pkg::IDX_CAP_LO, 16'h0f00);
    rc(tmr_pkg::IDX_IRQ_STATUS, 8'h00);
    wr(tmr_pkg::IDX_CLK_CTRL, 8'h00);
    wr(tmr_pkg::IDX_IRQ_MASK, 8'h07);
    wr(tmr_pkg::IDX_WAVE_CTRL, 8'h14);
    wr(tmr_pkg::IDX_FORCE_CTRL, 8'h80);
    chk({14'h0, wave_out_a, wave_out_b}, 16'h0002);
    wr(tmr_pkg::IDX_FORCE_CTRL, 8'h40);
    chk({14'h0, wave_out_a, wave_out_b}, 16'h0003);
    rc(tmr_pkg::IDX_FORCE_CTRL, 8'h00);
    rc(tmr_pkg::IDX_IRQ_STATUS, 8'h00);
    chk({15'h0, irq}, 16'h0000);
    wr(tmr_pkg::IDX_CLK_CTRL, 8'h08);
    wr16(tmr_pkg::IDX_CNT_LO, 16'h0042);
    wr(tmr_pkg::IDX_FORCE_CTRL, 8'h80);
    chk({14'h0, wave_out_a, wave_out_b}, 16'h0001);
    rd16(tmr_pkg::IDX_CNT_LO, 16'h0042);
    wr(tmr_pkg::IDX_CLK_CTRL, 8'h18);
    wr(tmr_pkg::IDX_WAVE_CTRL, 8'h16);
    wr(tmr_pkg::IDX_FORCE_CTRL, 8'hc0);
    chk({14'h0, wave_out_a, wave_out_b}, 16'h0001);
    stop_test();
  end
endmodule : tmr_top_test
